/* File: common/cca_map.vh */
// constants for the capture/compare counter array
// assumes one system clock and a synchronous active-low reset
`ifndef CCA_MAP_VH
`define CCA_MAP_VH
// ************************************
// clock sources
// ************************************
`define CCA_SRC_DIV12 3'h0
`define CCA_SRC_DIV4 3'h1
`define CCA_SRC_T0OVF 3'h2
`define CCA_SRC_EXTIN 3'h3
`define CCA_SRC_SYS 3'h4
`define CCA_SRC_XDIV8 3'h5
`define CCA_DIV12_LAST 4'hB
`define CCA_DIV4_LAST 2'h3
`define CCA_XDIV8_LAST 3'h7
// ************************************
// module modes
// ************************************
`define CCA_MODE_OFF 3'h0
`define CCA_MODE_CAPT 3'h1
`define CCA_MODE_STIM 3'h2
`define CCA_MODE_HSO 3'h3
`define CCA_MODE_PWM8 3'h4
`define CCA_MODE_PWM16 3'h5
`define CCA_MODE_FREQ 3'h6
`define CCA_MODE_WDOG 3'h7
// ************************************
// reset values
// ************************************
`define CCA_RST_COUNT 16'h0000
`define CCA_RST_WDOG_MATCH 16'hFFFF
`endif

/* File: hdl/cca_module.v */
// one capture/compare module of the counter array
// assumes count and tick come from the shared time base, all on clk_sys
`timescale 1ns/1ps
`include "cca_map.vh"
module cca_module (
  clk_sys,
  nrst,
  tick,
  count,
  mode,
  cap_rise,
  cap_fall,
  cmp_load,
  cmp_value,
  pin_in,
  pin_out,
  cmp_value_ff,
  event_ff
);
  input wire clk_sys;
  input wire nrst;
  input wire tick;
  input wire [15:0] count;
  input wire [2:0] mode;
  input wire cap_rise;
  input wire cap_fall;
  input wire cmp_load;
  input wire [15:0] cmp_value;
  input wire pin_in;
  output reg pin_out;
  output reg [15:0] cmp_value_ff;
  output reg event_ff;
  reg [1:0] sync_ff;
  reg prev_ff;
  reg [7:0] freq_cnt_ff;
  wire edge_hit;
  wire match;
  wire match8;
  assign edge_hit = (cap_rise & sync_ff[1] & ~prev_ff) | (cap_fall & ~sync_ff[1] & prev_ff);
  assign match = tick & (count == cmp_value_ff);
  assign match8 = tick & (count[7:0] == cmp_value_ff[7:0]);
  // ************************************
  // mode logic
  // ************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sync_ff <= 2'h0;
      prev_ff <= 1'b0;
      pin_out <= 1'b0;
      cmp_value_ff <= 16'h0000;
      event_ff <= 1'b0;
      freq_cnt_ff <= 8'h00;
    end else begin
      sync_ff <= {sync_ff[0], pin_in};
      prev_ff <= sync_ff[1];
      event_ff <= 1'b0;
      case (mode)
        `CCA_MODE_CAPT: begin
          if (edge_hit) begin
            cmp_value_ff <= count;
            event_ff <= 1'b1;
          end
        end
        `CCA_MODE_STIM: begin
          event_ff <= match;
        end
        `CCA_MODE_HSO: begin
          if (match) begin
            pin_out <= ~pin_out;
            event_ff <= 1'b1;
          end
        end
        `CCA_MODE_PWM8: begin
          if (tick) begin
            pin_out <= (count[7:0] >= cmp_value_ff[15:8]);
          end
          if (tick && count[7:0] == 8'hFF) begin
            cmp_value_ff[7:0] <= cmp_value_ff[15:8];
          end
        end
        `CCA_MODE_PWM16: begin
          if (tick) begin
            pin_out <= (count >= cmp_value_ff);
          end
        end
        `CCA_MODE_FREQ: begin
          if (match8) begin
            if (freq_cnt_ff == cmp_value_ff[15:8]) begin
              freq_cnt_ff <= 8'h00;
              pin_out <= ~pin_out;
            end else begin
              freq_cnt_ff <= freq_cnt_ff + 8'h01;
            end
          end
        end
        `CCA_MODE_WDOG: begin
          event_ff <= match;
        end
        default: begin
          pin_out <= 1'b0;
        end
      endcase
      if (cmp_load) begin
        cmp_value_ff <= cmp_value;
      end
    end
  end
endmodule

/* File: hdl/cca_top.v */
// counter array: shared time base, three capture/compare modules, watchdog on module two
// assumes pin inputs are asynchronous; control inputs are on clk_sys
`timescale 1ns/1ps
`include "cca_map.vh"
module cca_top (
  clk_sys,
  nrst,
  por_flag,
  debug_halt,
  clk_sel,
  run,
  t0_overflow,
  ext_osc,
  external_count_input,
  count_load,
  count_value,
  mode0,
  mode1,
  mode2,
  cap_rise,
  cap_fall,
  cmp_load,
  cmp_value,
  wdog_disable,
  wdog_lock,
  wdog_kick,
  pin_in,
  pin_out,
  count_ff,
  overflow_ff,
  cmp0,
  cmp1,
  cmp2,
  module_event,
  wdog_enabled_ff,
  wdog_locked_ff,
  wdog_reset_ff
);
  input wire clk_sys;
  input wire nrst;
  input wire por_flag;
  input wire debug_halt;
  input wire [2:0] clk_sel;
  input wire run;
  input wire t0_overflow;
  input wire ext_osc;
  input wire external_count_input;
  input wire count_load;
  input wire [15:0] count_value;
  input wire [2:0] mode0;
  input wire [2:0] mode1;
  input wire [2:0] mode2;
  input wire [2:0] cap_rise;
  input wire [2:0] cap_fall;
  input wire [2:0] cmp_load;
  input wire [15:0] cmp_value;
  input wire wdog_disable;
  input wire wdog_lock;
  input wire wdog_kick;
  input wire [2:0] pin_in;
  output wire [2:0] pin_out;
  output reg [15:0] count_ff;
  output reg overflow_ff;
  output wire [15:0] cmp0;
  output wire [15:0] cmp1;
  output wire [15:0] cmp2;
  output wire [2:0] module_event;
  output reg wdog_enabled_ff;
  output reg wdog_locked_ff;
  output reg wdog_reset_ff;
  reg [3:0] div_ff;
  reg [1:0] eci_sync_ff;
  reg eci_prev_ff;
  reg [1:0] xosc_sync_ff;
  reg xosc_prev_ff;
  reg [2:0] xdiv_ff;
  reg tick_src;
  wire tick;
  wire eci_rise;
  wire xosc_rise;
  wire [2:0] eff_mode2;
  wire [15:0] cmp_bus [0:2];
  wire [2:0] mode_bus [0:2];
  wire div12_tick;
  wire div4_tick;
  wire xdiv8_tick;
  wire wrap;
  wire wdog_hit;
  // ************************************
  // clock source selection
  // ************************************
  assign eci_rise = eci_sync_ff[1] & ~eci_prev_ff;
  assign xosc_rise = xosc_sync_ff[1] & ~xosc_prev_ff;
  assign div12_tick = (div_ff == `CCA_DIV12_LAST);
  assign div4_tick = (div_ff[1:0] == `CCA_DIV4_LAST);
  assign xdiv8_tick = xosc_rise & (xdiv_ff == `CCA_XDIV8_LAST);
  always @* begin
    case (clk_sel)
      `CCA_SRC_DIV12: tick_src = div12_tick;
      `CCA_SRC_DIV4: tick_src = div4_tick;
      `CCA_SRC_T0OVF: tick_src = t0_overflow;
      `CCA_SRC_EXTIN: tick_src = eci_rise;
      `CCA_SRC_SYS: tick_src = 1'b1;
      `CCA_SRC_XDIV8: tick_src = xdiv8_tick;
      default: tick_src = 1'b0;
    endcase
  end
  assign tick = tick_src & run & ~debug_halt;
  // ************************************
  // pin synchronisers and prescaler counters
  // ************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      eci_sync_ff <= 2'h0;
      eci_prev_ff <= 1'b0;
      xosc_sync_ff <= 2'h0;
      xosc_prev_ff <= 1'b0;
    end else begin
      eci_sync_ff <= {eci_sync_ff[0], external_count_input};
      eci_prev_ff <= eci_sync_ff[1];
      xosc_sync_ff <= {xosc_sync_ff[0], ext_osc};
      xosc_prev_ff <= xosc_sync_ff[1];
    end
  end
  always @(posedge clk_sys) begin
    if (!nrst) begin
      div_ff <= 4'h0;
      xdiv_ff <= 3'h0;
    end else begin
      if (!debug_halt) begin
        if (div_ff == `CCA_DIV12_LAST) begin
          div_ff <= 4'h0;
        end else begin
          div_ff <= div_ff + 4'h1;
        end
        if (xosc_rise) begin
          xdiv_ff <= xdiv_ff + 3'h1;
        end
      end
    end
  end
  // ************************************
  // time base
  // ************************************
  assign wrap = tick & (count_ff == 16'hFFFF);
  always @(posedge clk_sys) begin
    if (!nrst) begin
      count_ff <= `CCA_RST_COUNT;
    end else if (count_load) begin
      count_ff <= count_value;
    end else if (tick) begin
      count_ff <= count_ff + 16'h0001;
    end
  end
  // ************************************
  // overflow flag
  // ************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      overflow_ff <= 1'b0;
    end else if (wrap && !count_load) begin
      overflow_ff <= 1'b1;
    end
  end
  // ************************************
  // watchdog control
  // ************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wdog_enabled_ff <= 1'b1;
      wdog_locked_ff <= 1'b0;
      wdog_reset_ff <= 1'b0;
    end else begin
      if (wdog_lock && por_flag) begin
        wdog_locked_ff <= 1'b1;
      end
      if (wdog_disable && !wdog_locked_ff && !(wdog_lock && por_flag)) begin
        wdog_enabled_ff <= 1'b0;
      end
      wdog_reset_ff <= wdog_hit;
    end
  end
  assign wdog_hit = wdog_enabled_ff & module_event[2];
  // ************************************
  // mode steering
  // ************************************
  assign eff_mode2 = wdog_enabled_ff ? `CCA_MODE_WDOG : mode2;
  assign mode_bus[0] = (mode0 == `CCA_MODE_WDOG) ? `CCA_MODE_OFF : mode0;
  assign mode_bus[1] = (mode1 == `CCA_MODE_WDOG) ? `CCA_MODE_OFF : mode1;
  assign mode_bus[2] = eff_mode2;
  // ************************************
  // capture/compare modules
  // ************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_mod
      wire load_i;
      wire [15:0] val_i;
      assign load_i = (gi == 2 && wdog_enabled_ff) ? (wdog_kick | cmp_load[gi]) : cmp_load[gi];
      assign val_i = (gi == 2 && wdog_enabled_ff && wdog_kick) ?
        (count_ff + `CCA_RST_WDOG_MATCH) : cmp_value;
      cca_module u_cca_module (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(tick),
        .count(count_ff),
        .mode(mode_bus[gi]),
        .cap_rise(cap_rise[gi]),
        .cap_fall(cap_fall[gi]),
        .cmp_load(load_i),
        .cmp_value(val_i),
        .pin_in(pin_in[gi]),
        .pin_out(pin_out[gi]),
        .cmp_value_ff(cmp_bus[gi]),
        .event_ff(module_event[gi])
      );
    end
  endgenerate
  // ************************************
  // outputs
  // ************************************
  assign cmp0 = cmp_bus[0];
  assign cmp1 = cmp_bus[1];
  assign cmp2 = cmp_bus[2];
endmodule

/* File: tb/cca_checker.sv */
// concurrent checks on the counter array top ports
// assumes one clock clk_sys and a synchronous active-low nrst
`timescale 1ns/1ps
`include "cca_map.vh"
module cca_checker (
  input wire clk_sys,
  input wire nrst,
  input wire por_flag,
  input wire debug_halt,
  input wire [2:0] clk_sel,
  input wire run,
  input wire count_load,
  input wire wdog_disable,
  input wire wdog_lock,
  input wire [15:0] count_ff,
  input wire overflow_ff,
  input wire wdog_enabled_ff,
  input wire wdog_locked_ff,
  input wire wdog_reset_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ************************************
  // assertions
  // ************************************
  AST_WDOG_AT_RESET: assert property ($rose(nrst) |-> wdog_enabled_ff)
    else $error("watchdog not enabled after reset");
  AST_HALT_FREEZE: assert property ((debug_halt && !count_load)[*3] |-> $stable(count_ff))
    else $error("count moved while halted");
  AST_SYS_STEP: assert property ((clk_sel == `CCA_SRC_SYS && run && !debug_halt
    && !count_load)[*3] |-> count_ff == $past(count_ff) + 16'h0001)
    else $error("count not stepping on system clock");
  AST_WRAP_FLAG: assert property ((count_ff == 16'hFFFF && !count_load) ##1
    count_ff == 16'h0000 |-> ##[0:1] overflow_ff)
    else $error("no overflow flag on wrap");
  AST_FLAG_STICKY: assert property (overflow_ff |=> overflow_ff)
    else $error("overflow flag dropped");
  AST_WDOG_CAUSE: assert property (wdog_reset_ff |-> $past(wdog_enabled_ff))
    else $error("watchdog reset while disabled");
  AST_LOCK_POR: assert property ($rose(wdog_locked_ff) |-> $past(wdog_lock) && $past(por_flag))
    else $error("lock without power-on request");
  AST_DISABLE: assert property (wdog_disable && !wdog_lock && !wdog_locked_ff
    |=> !wdog_enabled_ff)
    else $error("watchdog disable ignored");
  cover property (overflow_ff);
  cover property (wdog_reset_ff);
  cover property (wdog_locked_ff);
endmodule
bind cca_top cca_checker u_cca_checker (.clk_sys(clk_sys), .nrst(nrst), .por_flag(por_flag),
  .debug_halt(debug_halt), .clk_sel(clk_sel), .run(run), .count_load(count_load),
  .wdog_disable(wdog_disable), .wdog_lock(wdog_lock), .count_ff(count_ff),
  .overflow_ff(overflow_ff), .wdog_enabled_ff(wdog_enabled_ff),
  .wdog_locked_ff(wdog_locked_ff), .wdog_reset_ff(wdog_reset_ff));

/* File: tb/test_capture_compare_array.sv */
// self-checking bench for the counter array top
// assumes cca_top and the checker are compiled before it
`timescale 1ns/1ps
`include "cca_map.vh"
module test_capture_compare_array;
  logic clk_sys, nrst, por_flag, debug_halt, run, t0_overflow, ext_osc, external_count_input;
  logic count_load, wdog_disable, wdog_lock, wdog_kick, seen;
  logic [2:0] clk_sel, mode0, mode1, mode2, cap_rise, cap_fall, cmp_load, pin_in;
  logic [15:0] count_value, cmp_value, c0;
  logic [31:0] cyc_cnt = 32'h0;
  wire [2:0] pin_out, module_event;
  wire [15:0] count_ff, cmp0, cmp1, cmp2;
  wire overflow_ff, wdog_enabled_ff, wdog_locked_ff, wdog_reset_ff;
  wire [3:0] ev = {wdog_reset_ff, module_event};
  int n_fail, checks_done, i;
  logic [2:0] row_sel [6] = '{`CCA_SRC_DIV12, `CCA_SRC_DIV4, `CCA_SRC_T0OVF,
    `CCA_SRC_EXTIN, `CCA_SRC_SYS, `CCA_SRC_XDIV8};
  logic [15:0] row_exp [6] = '{16'h0028, 16'h0078, 16'h0050, 16'h003C, 16'h01E0, 16'h000F};
  cca_top u_cca_top (.clk_sys(clk_sys), .nrst(nrst), .por_flag(por_flag),
    .debug_halt(debug_halt), .clk_sel(clk_sel), .run(run), .t0_overflow(t0_overflow),
    .ext_osc(ext_osc), .external_count_input(external_count_input),
    .count_load(count_load), .count_value(count_value), .mode0(mode0), .mode1(mode1),
    .mode2(mode2), .cap_rise(cap_rise), .cap_fall(cap_fall), .cmp_load(cmp_load),
    .cmp_value(cmp_value), .wdog_disable(wdog_disable), .wdog_lock(wdog_lock),
    .wdog_kick(wdog_kick), .pin_in(pin_in), .pin_out(pin_out), .count_ff(count_ff),
    .overflow_ff(overflow_ff), .cmp0(cmp0), .cmp1(cmp1), .cmp2(cmp2),
    .module_event(module_event), .wdog_enabled_ff(wdog_enabled_ff),
    .wdog_locked_ff(wdog_locked_ff), .wdog_reset_ff(wdog_reset_ff));
  // ************************************
  // clock, sources, timeout
  // ************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 32'h1;
    t0_overflow <= (cyc_cnt % 6 == 0);
    ext_osc <= cyc_cnt[1];
    external_count_input <= cyc_cnt[2];
    if (cyc_cnt == 32'h4E20) begin
      n_fail++;
      end_sim;
    end
  end
  // ************************************
  // tasks
  // ************************************
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task evw(input int b, input int lim);
    seen = 1'b0;
    repeat (lim) begin
      cyc(1);
      #1;
      if (ev[b] === 1'b1) seen = 1'b1;
    end
  endtask
  task do_rst(input logic por);
    cyc(1);
    por_flag <= por;
    nrst <= 1'b0;
    cyc(20);
    nrst <= 1'b1;
    cyc(1);
    #1;
  endtask
  task end_sim;
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ************************************
  // sequence
  // ************************************
  initial begin
    {nrst, por_flag, debug_halt, run} = 4'h0;
    {count_load, wdog_disable, wdog_lock, wdog_kick} = 4'h0;
    {clk_sel, mode0, mode1, mode2, cap_rise, cap_fall, cmp_load, pin_in} = 24'h000000;
    {count_value, cmp_value} = 32'h0;
    n_fail = 0;
    checks_done = 0;
    do_rst(1'b0);
    chk("wdog enabled", wdog_enabled_ff, 16'h0001);
    chk("count", count_ff, `CCA_RST_COUNT);
    chk("overflow", overflow_ff, 16'h0000);
    cyc(1);
    wdog_lock <= 1'b1;
    cyc(1);
    wdog_lock <= 1'b0;
    cyc(2);
    #1;
    chk("wdog locked", wdog_locked_ff, 16'h0000);
    cyc(1);
    clk_sel <= `CCA_SRC_SYS;
    run <= 1'b1;
    count_value <= 16'hFFF0;
    count_load <= 1'b1;
    cyc(1);
    count_load <= 1'b0;
    evw(3, 40);
    chk("wdog reset", seen, 16'h0001);
    chk("overflow", overflow_ff, 16'h0001);
    cyc(1);
    wdog_disable <= 1'b1;
    cyc(1);
    wdog_disable <= 1'b0;
    cyc(2);
    #1;
    chk("wdog enabled", wdog_enabled_ff, 16'h0000);
    cyc(1);
    count_load <= 1'b1;
    cyc(1);
    count_load <= 1'b0;
    evw(3, 40);
    chk("wdog reset", seen, 16'h0000);
    for (i = 0; i < 6; i++) begin
      cyc(1);
      clk_sel <= row_sel[i];
      cyc(40);
      #1;
      c0 = count_ff;
      cyc(480);
      #1;
      chk("count delta", count_ff - c0, row_exp[i]);
    end
    cyc(1);
    clk_sel <= `CCA_SRC_SYS;
    debug_halt <= 1'b1;
    cyc(4);
    #1;
    c0 = count_ff;
    cyc(20);
    #1;
    chk("halted count", count_ff, c0);
    cyc(1);
    debug_halt <= 1'b0;
    run <= 1'b0;
    count_value <= 16'h1234;
    count_load <= 1'b1;
    mode0 <= `CCA_MODE_CAPT;
    cap_rise <= 3'h1;
    cyc(1);
    count_load <= 1'b0;
    cyc(1);
    pin_in <= 3'h1;
    evw(0, 20);
    chk("capture event", seen, 16'h0001);
    chk("capture value", cmp0, 16'h1234);
    cyc(1);
    run <= 1'b1;
    mode1 <= `CCA_MODE_STIM;
    cmp_value <= count_ff + 16'h0020;
    cmp_load <= 3'h3;
    cyc(1);
    cmp_load <= 3'h0;
    mode0 <= `CCA_MODE_HSO;
    evw(1, 60);
    chk("timer match", seen, 16'h0001);
    chk("timer compare", cmp1, cmp_value);
    chk("output compare", cmp0, cmp_value);
    chk("fast output pin", pin_out, 16'h0001);
    cyc(1);
    mode1 <= `CCA_MODE_PWM16;
    cmp_value <= 16'h0000;
    cmp_load <= 3'h2;
    cyc(1);
    cmp_load <= 3'h0;
    cyc(2);
    #1;
    chk("pwm high", pin_out[1], 16'h0001);
    cyc(1);
    cmp_value <= 16'hFFFF;
    cmp_load <= 3'h2;
    cyc(1);
    cmp_load <= 3'h0;
    cyc(2);
    #1;
    chk("pwm low", pin_out[1], 16'h0000);
    do_rst(1'b1);
    chk("wdog enabled", wdog_enabled_ff, 16'h0001);
    cyc(1);
    wdog_lock <= 1'b1;
    cyc(1);
    wdog_lock <= 1'b0;
    wdog_disable <= 1'b1;
    cyc(1);
    wdog_disable <= 1'b0;
    cyc(2);
    #1;
    chk("wdog locked", wdog_locked_ff, 16'h0001);
    chk("wdog enabled", wdog_enabled_ff, 16'h0001);
    cyc(1);
    run <= 1'b0;
    count_value <= 16'h0100;
    count_load <= 1'b1;
    cyc(1);
    count_load <= 1'b0;
    wdog_kick <= 1'b1;
    cyc(1);
    wdog_kick <= 1'b0;
    cyc(1);
    #1;
    chk("watchdog compare", cmp2, 16'h00FF);
    end_sim;
  end
endmodule
